// ==== rtl/scts_cfg.svh ====
// Purpose: addresses, bit positions, reset value and timing figures of the
//          smart-card transfer status flags.
// Assumes: special-function-register bus with page select.
// Notes:   included by rtl/scts_pkg.sv and rtl/scts_status.sv.
`ifndef SCTS_CFG_SVH
`define SCTS_CFG_SVH

`define SCTS_CARD0_TSR_ADDR 8'hdf
`define SCTS_CARD1_TSR_ADDR 8'he7
`define SCTS_CARD2_TSR_ADDR 8'hef
`define SCTS_TSR_RESET 8'h0a

`define SCTS_BIT_ACT 7
`define SCTS_BIT_BREAK 6
`define SCTS_BIT_FRAME 5
`define SCTS_BIT_PARITY 4
`define SCTS_BIT_TX_VACANT 3
`define SCTS_BIT_TX_OVF 2
`define SCTS_BIT_RX_VACANT 1
`define SCTS_BIT_RX_OVR 0

// one character: start, 8 data, parity, stop
`define SCTS_CHAR_BITS 11
// clock cycles per elementary bit time at the system clock
`define SCTS_BIT_CYCLES 372

`endif

// ==== rtl/scts_pkg.sv ====
// Purpose: types shared by the transfer status logic.
// Assumes: nothing beyond the constants header.
// Notes:   field order of scts_tsr_t matches the register bit order.
`default_nettype none
`include "scts_cfg.svh"
package scts_pkg;

  // per-card events from the serial engine and the data register decode
  typedef struct packed {
    logic xfer_start;
    logic xfer_done;
    logic tx_load;
    logic dr_write;
    logic dr_read;
    logic rx_char;
    logic rx_stop_bit;
    logic rx_parity_ok;
    logic rx_line;
  } scts_evt_t;

  typedef struct packed {
    logic transfer_in_progress;
    logic break_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic tx_holding_vacant;
    logic tx_overflow_flag;
    logic rx_holding_vacant;
    logic rx_overrun_flag;
  } scts_tsr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic page2;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } scts_sfr_req_t;

endpackage
`default_nettype wire

// ==== rtl/scts_status.sv ====
// Purpose: transfer status flags of three smart-card serial channels.
// Assumes: the serial engine delivers one-cycle event pulses synchronous to clk_i.
// Notes:   status reads return data one cycle after the read strobe.
`default_nettype none
`include "scts_cfg.svh"

// Notes on behaviour
// - activity flag sets at transfer start, clears by itself when transfer ends.
// - receive line low longer than one whole character time sets break error.
// - low stop bit after last data or parity bit sets framing error.
// - received character with bad parity sets parity error.
// - software clears error flags by writing zero; only hardware sets them.
// - transmit vacant flag rises when buffered byte moves to shift register.
// - writing the data register clears the transmit vacant flag.
// - data register write while transmit buffer full sets transmit overflow.
// - CPU reading the received byte sets the receive vacant flag.
// - any newly received character clears the receive vacant flag.
// - character arriving with receive buffer occupied sets receive overrun.
// - error output is OR of five error flags, clears when all clear.
module scts_status
  import scts_pkg::*;
#(
  parameter int NCH = 3,
  parameter int BIT_CYCLES = `SCTS_BIT_CYCLES,
  parameter int CHAR_BITS = `SCTS_CHAR_BITS,
  parameter int BRK_W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire scts_sfr_req_t sfr_i,
  input wire scts_evt_t [NCH-1:0] evt_i,
  output logic [7:0] sfr_rdata_o,
  output scts_tsr_t [NCH-1:0] tsr_o,
  output logic [NCH-1:0] transfer_error_irq_flag_o
);

  localparam logic [BRK_W-1:0] BRK_LIMIT = BRK_W'(BIT_CYCLES * CHAR_BITS);

  // decode one status register address to its channel, or none
  function automatic logic [2:0] hit_of(input logic [7:0] addr, input logic page2);
    logic [2:0] h;
    h = 3'h0;
    if (page2)
    begin
      h[0] = (addr == `SCTS_CARD0_TSR_ADDR);
      h[1] = (addr == `SCTS_CARD1_TSR_ADDR);
      h[2] = (addr == `SCTS_CARD2_TSR_ADDR);
    end
    return h;
  endfunction

  scts_tsr_t [NCH-1:0] tsr_ff;
  scts_tsr_t [NCH-1:0] nxt_tsr;
  logic [NCH-1:0][BRK_W-1:0] low_cnt_ff;
  logic [NCH-1:0][BRK_W-1:0] nxt_low_cnt;
  logic [NCH-1:0] terr_ff;
  logic [NCH-1:0] nxt_terr;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] hit;

  always_comb
  begin
    hit = hit_of(sfr_i.addr, sfr_i.page2);
    nxt_tsr = tsr_ff;
    nxt_low_cnt = low_cnt_ff;
    nxt_terr = terr_ff;
    for (int c = 0; c < NCH; c++)
    begin
      // software write: only zeros clear, ones and read-only bits are ignored
      if (sfr_i.wr && hit[c])
      begin
        nxt_tsr[c].break_error_flag =
          tsr_ff[c].break_error_flag & sfr_i.wdata[`SCTS_BIT_BREAK];
        nxt_tsr[c].framing_error_flag =
          tsr_ff[c].framing_error_flag & sfr_i.wdata[`SCTS_BIT_FRAME];
        nxt_tsr[c].parity_error_flag =
          tsr_ff[c].parity_error_flag & sfr_i.wdata[`SCTS_BIT_PARITY];
        nxt_tsr[c].tx_overflow_flag =
          tsr_ff[c].tx_overflow_flag & sfr_i.wdata[`SCTS_BIT_TX_OVF];
        nxt_tsr[c].rx_overrun_flag =
          tsr_ff[c].rx_overrun_flag & sfr_i.wdata[`SCTS_BIT_RX_OVR];
      end

      // hardware sets below override a clear in the same cycle
      if (evt_i[c].xfer_done)
        nxt_tsr[c].transfer_in_progress = 1'b0;
      if (evt_i[c].xfer_start)
        nxt_tsr[c].transfer_in_progress = 1'b1;

      // count low time; flag once when past a full character, then saturate
      if (evt_i[c].rx_line)
        nxt_low_cnt[c] = '0;
      else if (low_cnt_ff[c] <= BRK_LIMIT)
        nxt_low_cnt[c] = low_cnt_ff[c] + BRK_W'(1);
      if (!evt_i[c].rx_line && low_cnt_ff[c] == BRK_LIMIT)
        nxt_tsr[c].break_error_flag = 1'b1;

      if (evt_i[c].rx_char)
      begin
        if (!evt_i[c].rx_stop_bit)
          nxt_tsr[c].framing_error_flag = 1'b1;
        if (!evt_i[c].rx_parity_ok)
          nxt_tsr[c].parity_error_flag = 1'b1;
        // a read in the same cycle frees the buffer for this character
        if (!tsr_ff[c].rx_holding_vacant && !evt_i[c].dr_read)
          nxt_tsr[c].rx_overrun_flag = 1'b1;
        nxt_tsr[c].rx_holding_vacant = 1'b0;
      end
      else if (evt_i[c].dr_read)
        nxt_tsr[c].rx_holding_vacant = 1'b1;

      if (evt_i[c].dr_write)
      begin
        // a load in the same cycle empties the buffer, so no overflow then
        if (!tsr_ff[c].tx_holding_vacant && !evt_i[c].tx_load)
          nxt_tsr[c].tx_overflow_flag = 1'b1;
        nxt_tsr[c].tx_holding_vacant = 1'b0;
      end
      else if (evt_i[c].tx_load)
        nxt_tsr[c].tx_holding_vacant = 1'b1;

      // taken from next values so the output stays in step with the flags
      nxt_terr[c] = nxt_tsr[c].break_error_flag | nxt_tsr[c].framing_error_flag
        | nxt_tsr[c].parity_error_flag | nxt_tsr[c].tx_overflow_flag
        | nxt_tsr[c].rx_overrun_flag;
    end

    nxt_rdata = rdata_ff;
    if (sfr_i.rd)
    begin
      nxt_rdata = 8'h00;
      for (int c = 0; c < NCH; c++)
        if (hit[c])
          nxt_rdata = tsr_ff[c];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tsr_ff <= {NCH{`SCTS_TSR_RESET}};
      low_cnt_ff <= '0;
      terr_ff <= '0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      tsr_ff <= nxt_tsr;
      low_cnt_ff <= nxt_low_cnt;
      terr_ff <= nxt_terr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata_o = rdata_ff;
  assign tsr_o = tsr_ff;
  assign transfer_error_irq_flag_o = terr_ff;

endmodule
`default_nettype wire

// ==== verification/scts_card_model.sv ====
// Purpose: card side of the receive line
// Assumes: one character per go pulse
// Notes: flag lines toggle when idle
`default_nettype none
module scts_card_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] fl_i,
  input wire logic brk_i,
  output logic rc_o,
  output logic [1:0] fl_o,
  output logic rl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rc_o, fl_o} = 3'h0;
  always @(posedge clk_i)
  begin
    rc_o <= #1 go_i;
    fl_o <= #1 go_i ? fl_i : ~fl_o; // junk off the char, never stale
  end
  assign rl_o = !brk_i;
endmodule
`default_nettype wire

// ==== verification/scts_status_properties.sv ====
// Purpose: card 0 flag properties
// Assumes: cards share no state
// Notes: bound at the foot
`default_nettype none
module scts_status_props
  import scts_pkg::*;
#(parameter int NCH = 3)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire scts_sfr_req_t sfr_i,
  input wire scts_evt_t [NCH-1:0] evt_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire scts_tsr_t [NCH-1:0] tsr_o,
  input wire logic [NCH-1:0] transfer_error_irq_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  scts_evt_t e;
  scts_tsr_t t;
  assign e = evt_i[0];
  assign t = tsr_o[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // quiet events only, so a set cannot mask the write
  sequence s_w;
    sfr_i.wr && sfr_i.page2 && sfr_i.addr == 8'hdf && e == 9'h001;
  endsequence
  property p_act; e.xfer_start |=> t[7]; endproperty
  a_act: assert property (p_act) else $error("act");
  property p_frm; e.rx_char && !e.rx_stop_bit |=> t[5]; endproperty
  a_frm: assert property (p_frm) else $error("frm");
  property p_txe; e.tx_load && !e.dr_write |=> t[3]; endproperty
  a_txe: assert property (p_txe) else $error("txe");
  // a load in the same cycle frees the buffer, so no overflow then
  property p_txo; e.dr_write && !e.tx_load && !t[3] |=> t[2]; endproperty
  a_txo: assert property (p_txo) else $error("txo");
  property p_rxe; e.rx_char |=> !t[1]; endproperty
  a_rxe: assert property (p_rxe) else $error("rxe");
  property p_irq; transfer_error_irq_flag_o[0] == |(t & 8'h75); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_clr; s_w ##0 sfr_i.wdata == 8'h00 |=> (t & 8'h75) == 0; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_ro; s_w ##0 sfr_i.wdata == 8'hff |=> t == $past(t); endproperty
  a_ro: assert property (p_ro) else $error("ro");
endmodule
bind scts_status scts_status_props #(.NCH(NCH)) scts_status_props_i (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .sfr_i(sfr_i), .evt_i(evt_i), .sfr_rdata_o(sfr_rdata_o),
  .tsr_o(tsr_o), .transfer_error_irq_flag_o(transfer_error_irq_flag_o));
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: random status test
// Assumes: break at 45 low cycles
// Notes: all cards see the same events
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scts_pkg::*;
  logic clk_i = 0, rst_n_i = 0, go = 0, brk = 0, rc, rl;
  logic [1:0] fl = 0, fo;
  scts_sfr_req_t sfr_i = '0;
  scts_evt_t ev = '0, e;
  logic [7:0] sfr_rdata_o, m = 8'h0a;
  scts_tsr_t [2:0] tsr_o;
  logic [2:0] irq;
  int n_errors = 0, checked = 0, seed = 62, op, k;
  always_comb
  begin
    e = ev;
    e.rx_char = rc;
    {e.rx_stop_bit, e.rx_parity_ok} = fo;
    e.rx_line = rl;
  end
  scts_status #(.BIT_CYCLES(4)) scts_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sfr_i(sfr_i), .evt_i({3{e}}), .sfr_rdata_o(sfr_rdata_o), .tsr_o(tsr_o),
    .transfer_error_irq_flag_o(irq));
  scts_card_model scts_card_model_i (.clk_i(clk_i), .go_i(go), .fl_i(fl),
    .brk_i(brk), .rc_o(rc), .fl_o(fo), .rl_o(rl));
  initial forever #10 clk_i = ~clk_i;
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(string s, logic [7:0] x, logic [7:0] g);
    checked++;
    if (g !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(logic r, logic [7:0] a, logic [7:0] d);
    sfr_i = '{a, 1'b1, !r, r, d};
    tick();
    // idle cycle so back-to-back accesses never re-drive the strobe in one step
    sfr_i = '0;
    tick();
  endtask
  task automatic cmp(int c);
    acc(1, 8'(8'hdf + 8 * c), 0);
    chk("tsr", m, sfr_rdata_o);
    chk("irq", {7'h0, |(m & 8'h75)}, {7'h0, irq[c]});
  endtask
  task automatic clr(logic [7:0] d);
    for (int i = 0; i < 3; i++)
      acc(0, 8'(8'hdf + 8 * i), d);
    m &= {1'b1, d[6:4], 1'b1, d[2], 1'b1, d[0]};
  endtask
  initial
  begin
    tick(3);
    rst_n_i = 1;
    for (k = 0; k < 3; k++)
      cmp(k);
    acc(1, 8'hde, 8'hff);
    chk("unmapped", 8'h00, sfr_rdata_o);
    clr(8'hff);
    repeat (80)
    begin
      op = $unsigned($random(seed)) % 7;
      if (op < 5)
      begin
        ev = 9'h100 >> op;
        tick();
        ev = '0;
        m[7] = op == 0 || (m[7] && op != 1);
        m[2] |= op == 3 && !m[3];
        m[3] = op == 2 || (m[3] && op != 3);
        m[1] |= op == 4;
      end
      else if (op == 5)
      begin
        fl = 2'($random(seed));
        go = 1;
        tick();
        go = 0;
        tick();
        m[5] |= !fl[1];
        m[4] |= !fl[0];
        m[0] |= !m[1];
        m[1] = 0;
      end
      else
        clr(8'($random(seed)));
      cmp($unsigned($random(seed)) % 3);
    end
    clr(0);
    brk = 1;
    tick(44);
    chk("brk", 8'h00, {7'h0, tsr_o[0][6]});
    tick();
    m[6] = 1;
    chk("brk", 8'h01, {7'h0, tsr_o[0][6]});
    brk = 0;
    cmp(2);
    finish_test();
  end
  initial
  begin
    #100us;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
